/* File: src/adc_cfg_params.svh */
// Offsets, field positions, reset values and write masks for the config bank
`ifndef ADC_CFG_PARAMS_SVH
`define ADC_CFG_PARAMS_SVH

`define RANGE_BUFFER_CONFIG_ADDR 4'h5
`define POWER_SPEED_START_CONFIG_ADDR 4'h6
`define RANGE_BUFFER_CONFIG_RESET 8'h00
`define POWER_SPEED_START_CONFIG_RESET 8'h00
`define RANGE_BUFFER_CONFIG_MASK 8'h7b
`define POWER_SPEED_START_CONFIG_MASK 8'hbf

`define REF_RANGE_BIT 6
`define INPUT_RANGE_BIT 5
`define CM_OUT_BIT 4
`define POS_REF_BUF_BIT 3
`define POS_IN_BUF_BIT 1
`define NEG_IN_BUF_BIT 0

`define EXT_RANGE_BIT 7
`define SERIAL_MODE_BIT 5
`define START_MODE_HI 4
`define START_MODE_LO 3
`define SPEED_BIT 2
`define STANDBY_BIT 1
`define POWER_DOWN_BIT 0

`define UNMAPPED_READ 8'h00

`endif

/* File: src/adc_cfg_pkg.sv */
// Types shared by the configuration register bank
package adc_cfg_pkg;

  typedef enum logic [1:0] {
    START_STOP_MODE,
    ONE_SHOT_MODE,
    SYNCHRONIZED_MODE,
    START_RESERVED_MODE
  } start_mode_t;

  typedef struct packed {
    logic reference_range_select;
    logic input_gain_range_select;
    logic common_mode_output_enable;
    logic pos_reference_precharge_enable;
    logic pos_input_precharge_enable;
    logic neg_input_precharge_enable;
  } range_ctrl_t;

  typedef struct packed {
    logic extended_range_enable;
    logic serial_out_pin_mode;
    logic [1:0] start_mode;
    logic low_speed_select;
    logic auto_standby_enable;
    logic power_down_select;
  } power_ctrl_t;

  typedef enum {
    PWR_ACTIVE,
    PWR_IDLE,
    PWR_STANDBY,
    PWR_DOWN
  } power_state_t;

endpackage

/* File: src/range_decode.sv */
// Effective analog range controls derived from the range register
`timescale 1ns/1ps
`default_nettype none
module range_decode
  import adc_cfg_pkg::*;
(
  input wire range_ctrl_t ctrl_in,
  output logic one_x_forced_out,
  output logic effective_two_x_out
);

  // High reference range overrides the programmed input range
  always_comb begin
    one_x_forced_out = ctrl_in.reference_range_select;
    effective_two_x_out = ctrl_in.input_gain_range_select &
      ~ctrl_in.reference_range_select;
  end

endmodule
`default_nettype wire

/* File: src/power_sequencer.sv */
// Power state tracking for idle, auto standby and power down
`timescale 1ns/1ps
`default_nettype none
module power_sequencer
  import adc_cfg_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic converting_in,
  input wire logic auto_standby_in,
  input wire logic power_down_in,
  output var power_state_t state_out
);

  power_state_t state;
  power_state_t next_state;

  // Power down dominates; standby leaves as soon as conversions restart
  always_comb begin
    next_state = state;
    case (state)
      PWR_ACTIVE: begin
        if (power_down_in) begin
          next_state = PWR_DOWN;
        end else if (!converting_in) begin
          next_state = auto_standby_in ? PWR_STANDBY : PWR_IDLE;
        end
      end
      PWR_IDLE, PWR_STANDBY: begin
        if (power_down_in) begin
          next_state = PWR_DOWN;
        end else if (converting_in) begin
          next_state = PWR_ACTIVE;
        end else begin
          next_state = auto_standby_in ? PWR_STANDBY : PWR_IDLE;
        end
      end
      PWR_DOWN: begin
        if (!power_down_in) begin
          next_state = converting_in ? PWR_ACTIVE : PWR_IDLE;
        end
      end
      default: begin
        next_state = PWR_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= PWR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign state_out = state;

endmodule
`default_nettype wire

/* File: src/adc_config_regs.sv */
// Range and power configuration register bank of the converter
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_params.svh"
module adc_config_regs
  import adc_cfg_pkg::*;
#(
  parameter int ADDR_WIDTH = 4,
  parameter int DATA_WIDTH = 8
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [ADDR_WIDTH-1:0] addr_in,
  input wire logic [DATA_WIDTH-1:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire logic converting_in,
  output logic [DATA_WIDTH-1:0] rdata_out,
  output logic reference_range_select_out,
  output logic input_two_x_out,
  output logic one_x_forced_out,
  output logic common_mode_output_enable_out,
  output logic pos_reference_precharge_enable_out,
  output logic pos_input_precharge_enable_out,
  output logic neg_input_precharge_enable_out,
  output logic extended_range_enable_out,
  output logic serial_out_pin_mode_out,
  output logic [1:0] start_mode_out,
  output logic low_speed_select_out,
  output logic auto_standby_enable_out,
  output logic power_down_select_out,
  output logic analog_powered_out,
  output logic standby_active_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (DATA_WIDTH != 8) begin : g_bad_width
    $error("adc_config_regs: DATA_WIDTH must be 8");
  end
  if (ADDR_WIDTH < 3) begin : g_bad_addr
    $error("adc_config_regs: ADDR_WIDTH must be at least 3");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode helper, used for write and read paths

  function automatic logic hits(input logic [ADDR_WIDTH-1:0] a,
                                input logic [3:0] target);
    hits = (a == ADDR_WIDTH'(target));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0] range_buffer_config;
  logic [7:0] power_speed_start_config;
  range_ctrl_t range_ctrl;
  power_ctrl_t power_ctrl;
  logic one_x_forced;
  logic effective_two_x;
  power_state_t power_state;

  // Range register; reserved bits 7 and 2 are masked out on write
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      range_buffer_config <= `RANGE_BUFFER_CONFIG_RESET;
    end else if (write_in && hits(addr_in, `RANGE_BUFFER_CONFIG_ADDR)) begin
      range_buffer_config <= wdata_in & `RANGE_BUFFER_CONFIG_MASK;
    end
  end

  // Power register; reserved bit 6 masked; reserved start code stored as is
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      power_speed_start_config <= `POWER_SPEED_START_CONFIG_RESET;
    end else if (write_in &&
                 hits(addr_in, `POWER_SPEED_START_CONFIG_ADDR)) begin
      power_speed_start_config <=
        wdata_in & `POWER_SPEED_START_CONFIG_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction

  // Named views of the stored bits
  always_comb begin
    range_ctrl.reference_range_select =
      range_buffer_config[`REF_RANGE_BIT];
    range_ctrl.input_gain_range_select =
      range_buffer_config[`INPUT_RANGE_BIT];
    range_ctrl.common_mode_output_enable =
      range_buffer_config[`CM_OUT_BIT];
    range_ctrl.pos_reference_precharge_enable =
      range_buffer_config[`POS_REF_BUF_BIT];
    range_ctrl.pos_input_precharge_enable =
      range_buffer_config[`POS_IN_BUF_BIT];
    range_ctrl.neg_input_precharge_enable =
      range_buffer_config[`NEG_IN_BUF_BIT];
    power_ctrl.extended_range_enable =
      power_speed_start_config[`EXT_RANGE_BIT];
    power_ctrl.serial_out_pin_mode =
      power_speed_start_config[`SERIAL_MODE_BIT];
    power_ctrl.start_mode =
      power_speed_start_config[`START_MODE_HI:`START_MODE_LO];
    power_ctrl.low_speed_select =
      power_speed_start_config[`SPEED_BIT];
    power_ctrl.auto_standby_enable =
      power_speed_start_config[`STANDBY_BIT];
    power_ctrl.power_down_select =
      power_speed_start_config[`POWER_DOWN_BIT];
  end

  range_decode u_range_decode (
    .ctrl_in(range_ctrl),
    .one_x_forced_out(one_x_forced),
    .effective_two_x_out(effective_two_x)
  );

  power_sequencer u_power_sequencer (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .converting_in(converting_in),
    .auto_standby_in(power_ctrl.auto_standby_enable),
    .power_down_in(power_ctrl.power_down_select),
    .state_out(power_state)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path: data valid the cycle after the strobe, zero otherwise

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= `UNMAPPED_READ;
    end else if (read_in && hits(addr_in, `RANGE_BUFFER_CONFIG_ADDR)) begin
      rdata_out <= range_buffer_config;
    end else if (read_in &&
                 hits(addr_in, `POWER_SPEED_START_CONFIG_ADDR)) begin
      rdata_out <= power_speed_start_config;
    end else begin
      rdata_out <= `UNMAPPED_READ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs, registered so the analog side sees clean levels.
  // They lag the register write by one cycle, the power status outputs by two.

  // Reference and input range
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reference_range_select_out <= 1'b0;
      input_two_x_out <= 1'b0;
      one_x_forced_out <= 1'b0;
    end else begin
      reference_range_select_out <= range_ctrl.reference_range_select;
      input_two_x_out <= effective_two_x;
      one_x_forced_out <= one_x_forced;
    end
  end

  // Buffers and common-mode pin; off while power down is selected
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      common_mode_output_enable_out <= 1'b0;
      pos_reference_precharge_enable_out <= 1'b0;
      pos_input_precharge_enable_out <= 1'b0;
      neg_input_precharge_enable_out <= 1'b0;
    end else begin
      common_mode_output_enable_out <=
        range_ctrl.common_mode_output_enable &
        ~power_ctrl.power_down_select;
      pos_reference_precharge_enable_out <=
        range_ctrl.pos_reference_precharge_enable &
        ~power_ctrl.power_down_select;
      pos_input_precharge_enable_out <=
        range_ctrl.pos_input_precharge_enable &
        ~power_ctrl.power_down_select;
      neg_input_precharge_enable_out <=
        range_ctrl.neg_input_precharge_enable &
        ~power_ctrl.power_down_select;
    end
  end

  // Mode selects; the reserved start code is passed on unchanged
  // because the host is bound never to write it
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      extended_range_enable_out <= 1'b0;
      serial_out_pin_mode_out <= 1'b0;
      start_mode_out <= 2'h0;
      low_speed_select_out <= 1'b0;
      auto_standby_enable_out <= 1'b0;
      power_down_select_out <= 1'b0;
    end else begin
      extended_range_enable_out <= power_ctrl.extended_range_enable;
      serial_out_pin_mode_out <= power_ctrl.serial_out_pin_mode;
      start_mode_out <= power_ctrl.start_mode;
      low_speed_select_out <= power_ctrl.low_speed_select;
      auto_standby_enable_out <= power_ctrl.auto_standby_enable;
      power_down_select_out <= power_ctrl.power_down_select;
    end
  end

  // Analog power status from the sequencer
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      analog_powered_out <= 1'b0;
      standby_active_out <= 1'b0;
    end else begin
      analog_powered_out <= (power_state == PWR_ACTIVE) ||
                            (power_state == PWR_IDLE);
      standby_active_out <= (power_state == PWR_STANDBY);
    end
  end

endmodule
`default_nettype wire

/* File: dv/adc_cfg_monitor.sv */
// Checker for the range and power configuration bank
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_monitor (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire logic converting_in,
  input wire logic [7:0] rdata_out,
  input wire logic reference_range_select_out,
  input wire logic input_two_x_out,
  input wire logic one_x_forced_out,
  input wire logic common_mode_output_enable_out,
  input wire logic [1:0] start_mode_out,
  input wire logic auto_standby_enable_out,
  input wire logic power_down_select_out,
  input wire logic standby_active_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // Register writes show at the outputs two edges after the strobe
  sequence wr_range;
    write_in && addr_in == 4'h5 ##2 1;
  endsequence
  ref_range_a: assert property (
    wr_range |-> reference_range_select_out == $past(wdata_in[6], 2))
    else $error("reference range output wrong");
  force_one_a: assert property (
    one_x_forced_out == reference_range_select_out
    && !(input_two_x_out && one_x_forced_out))
    else $error("high reference does not force 1x");
  two_x_a: assert property (
    wr_range |-> input_two_x_out ==
    ($past(wdata_in[5], 2) && !$past(wdata_in[6], 2)))
    else $error("input range output wrong");
  start_mode_a: assert property (
    write_in && addr_in == 4'h6 ##2 1 |->
    start_mode_out == $past(wdata_in[4:3], 2))
    else $error("start mode output wrong");
  reserved_zero_a: assert property (
    read_in && addr_in == 4'h5 |=> (rdata_out & 8'h84) == 8'h00)
    else $error("reserved range bits not zero");
  unmapped_read_a: assert property (
    read_in && addr_in != 4'h5 && addr_in != 4'h6 |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  pd_cm_off_a: assert property (
    power_down_select_out && $past(power_down_select_out)
    |-> !common_mode_output_enable_out)
    else $error("common mode kept on in power down");
  auto_sby_a: assert property (
    (auto_standby_enable_out && !power_down_select_out && !converting_in)
    [*4] |-> standby_active_out)
    else $error("auto standby not entered");
  wake_a: assert property (
    $rose(converting_in) |-> ##[1:3] !standby_active_out)
    else $error("standby kept after restart");
  cover property (wr_range);
  cover property ($rose(standby_active_out));
  cover property ($rose(power_down_select_out));
endmodule
bind adc_config_regs adc_cfg_monitor mon (
  .clock_in(clock_in),
  .rst_b_in(rst_b_in),
  .addr_in(addr_in),
  .wdata_in(wdata_in),
  .write_in(write_in),
  .read_in(read_in),
  .converting_in(converting_in),
  .rdata_out(rdata_out),
  .reference_range_select_out(reference_range_select_out),
  .input_two_x_out(input_two_x_out),
  .one_x_forced_out(one_x_forced_out),
  .common_mode_output_enable_out(common_mode_output_enable_out),
  .start_mode_out(start_mode_out),
  .auto_standby_enable_out(auto_standby_enable_out),
  .power_down_select_out(power_down_select_out),
  .standby_active_out(standby_active_out)
);
`default_nettype wire

/* File: dv/cfg_host_model.sv */
// Host model speaking the register port
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
  input wire logic clock_in,
  input wire logic [7:0] rdata_in,
  output logic [3:0] addr_out,
  output logic [7:0] wdata_out,
  output logic write_out,
  output logic read_out
);
  // Idle bus at time zero
  initial begin
    addr_out = 4'h0;
    wdata_out = 8'h00;
    write_out = 1'b0;
    read_out = 1'b0;
  end
  // Released lines are inverted so stale values cannot pass
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_out <= a;
    wdata_out <= d;
    write_out <= 1'b1;
    @(posedge clock_in);
    write_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_in);
    addr_out <= a;
    read_out <= 1'b1;
    @(posedge clock_in);
    read_out <= 1'b0;
    addr_out <= ~a;
    #1 d = rdata_in;
  endtask
endmodule
`default_nettype wire

/* File: dv/adc_config_regs_tb.sv */
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module adc_config_regs_tb;
  logic clock_in = 1'b0;
  logic rst_b_in, converting_in, write_in, read_in;
  logic [3:0] addr_in;
  logic [7:0] wdata_in, rdata_out, r;
  logic reference_range_select_out, input_two_x_out, one_x_forced_out;
  logic common_mode_output_enable_out, pos_reference_precharge_enable_out;
  logic pos_input_precharge_enable_out, neg_input_precharge_enable_out;
  logic extended_range_enable_out, serial_out_pin_mode_out;
  logic low_speed_select_out, auto_standby_enable_out;
  logic power_down_select_out, analog_powered_out, standby_active_out;
  logic [1:0] start_mode_out;
  int num_errors = 0;
  int total_checks = 0;
  // Outputs laid out on the register bit positions; bit 7 is the force
  wire [7:0] range_view = {one_x_forced_out, reference_range_select_out,
    input_two_x_out, common_mode_output_enable_out,
    pos_reference_precharge_enable_out, 1'b0,
    pos_input_precharge_enable_out, neg_input_precharge_enable_out};
  wire [7:0] power_view = {extended_range_enable_out, 1'b0,
    serial_out_pin_mode_out, start_mode_out, low_speed_select_out,
    auto_standby_enable_out, power_down_select_out};
  wire [7:0] state_view = {5'h00, common_mode_output_enable_out,
    standby_active_out, analog_powered_out};
  logic [7:0] range_tab [5] = '{8'hff, 8'h3b, 8'h24, 8'h52, 8'h00};
  logic [7:0] power_tab [4] = '{8'h08, 8'hb4, 8'h6a, 8'h00};
  always #12.5 clock_in = ~clock_in;
  adc_config_regs dut (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .write_in(write_in),
    .read_in(read_in),
    .converting_in(converting_in),
    .rdata_out(rdata_out),
    .reference_range_select_out(reference_range_select_out),
    .input_two_x_out(input_two_x_out),
    .one_x_forced_out(one_x_forced_out),
    .common_mode_output_enable_out(common_mode_output_enable_out),
    .pos_reference_precharge_enable_out(pos_reference_precharge_enable_out),
    .pos_input_precharge_enable_out(pos_input_precharge_enable_out),
    .neg_input_precharge_enable_out(neg_input_precharge_enable_out),
    .extended_range_enable_out(extended_range_enable_out),
    .serial_out_pin_mode_out(serial_out_pin_mode_out),
    .start_mode_out(start_mode_out),
    .low_speed_select_out(low_speed_select_out),
    .auto_standby_enable_out(auto_standby_enable_out),
    .power_down_select_out(power_down_select_out),
    .analog_powered_out(analog_powered_out),
    .standby_active_out(standby_active_out)
  );
  cfg_host_model host (.clock_in(clock_in), .rdata_in(rdata_out),
    .addr_out(addr_in), .wdata_out(wdata_in), .write_out(write_in),
    .read_out(read_in));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Long enough for a register change to ripple into the power state
  task automatic settle;
    repeat (4) @(posedge clock_in);
    #1;
  endtask
  task automatic t_reset;
    host.rd(4'h5, r);
    chk(r, 8'h00);
    host.rd(4'h6, r);
    chk(r, 8'h00);
    host.wr(4'hf, 8'hff);
    host.rd(4'hf, r);
    chk(r, 8'h00);
    settle;
    chk(range_view, 8'h00);
    chk(power_view, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_range;
    logic [7:0] d;
    foreach (range_tab[i]) begin
      d = range_tab[i];
      host.wr(4'h5, d);
      host.rd(4'h5, r);
      chk(r, d & 8'h7b);
      settle;
      chk(range_view, {d[6], d[6], d[5] & ~d[6], d[4:3], 1'b0, d[1:0]});
    end
    $display("range test done");
  endtask
  task automatic t_power;
    logic [7:0] d;
    foreach (power_tab[i]) begin
      d = power_tab[i];
      host.wr(4'h6, d);
      host.rd(4'h6, r);
      chk(r, d & 8'hbf);
      settle;
      chk(power_view, d & 8'hbf);
    end
    $display("power test done");
  endtask
  // Level changes wait for a rising edge so they stay on the clock grid
  task automatic t_standby;
    @(posedge clock_in);
    converting_in <= 1'b1;
    host.wr(4'h6, 8'h02);
    settle;
    chk(state_view, 8'h01);
    @(posedge clock_in);
    converting_in <= 1'b0;
    settle;
    chk(state_view, 8'h02);
    @(posedge clock_in);
    converting_in <= 1'b1;
    settle;
    chk(state_view, 8'h01);
    @(posedge clock_in);
    converting_in <= 1'b0;
    host.wr(4'h6, 8'h00);
    settle;
    chk(state_view, 8'h01);
    host.wr(4'h5, 8'h1b);
    host.wr(4'h6, 8'h01);
    settle;
    chk(state_view, 8'h00);
    chk(range_view, 8'h00);
    host.rd(4'h5, r);
    chk(r, 8'h1b);
    host.wr(4'h6, 8'h00);
    settle;
    chk(state_view, 8'h05);
    chk(range_view, 8'h1b);
    $display("standby test done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Main sequence after a 20 cycle reset
  initial begin
    rst_b_in = 1'b0;
    converting_in = 1'b0;
    repeat (20) @(posedge clock_in);
    rst_b_in <= 1'b1;
    t_reset;
    t_range;
    t_power;
    t_standby;
    summarize;
  end
  // Watchdog at about fourteen times the expected run
  initial begin
    #50000;
    num_errors++;
    summarize;
  end
endmodule
`default_nettype wire
